// ===== config_literal_decode.sv
// Purpose: Decode and execute the config-load and literal-return instructions
// Assumes: Fetch logic holds the next instruction while flush is high
// Notes: Status flags are never touched, so no flag port exists
`default_nettype none
module config_literal_decode (
  input wire logic core_clk,
  input wire logic rst,
  input wire decode_pkg::instr_t instr,
  input wire logic [7:0] w_reg,
  input wire logic [12:0] stack_top,
  input wire decode_pkg::file_access_t file_acc,
  output logic [7:0] cfg,
  output logic [7:0] file_rdata,
  output logic [7:0] w_data,
  output logic w_load,
  output logic [12:0] pc_data,
  output logic pc_load,
  output logic stack_pop,
  output logic flush,
  output logic done
);
  decode_pkg::state_t s, next_s;

  logic cfg_load_hit;
  logic lit_return_hit;
  logic cfg_write_hit;
  logic cfg_read_hit;

  function automatic logic is_lit_return(input logic [13:0] word);
    return word[decode_pkg::TOP_HI:decode_pkg::TOP_LO] == decode_pkg::LIT_RETURN_TOP;
  endfunction

  function automatic logic is_cfg_addr(input logic [7:0] addr);
    return addr == decode_pkg::CFG_ADDR;
  endfunction

  // Decode kept apart from sequencing so the state update reads as priority only
  always_comb begin
    cfg_load_hit = instr.valid && instr.word == decode_pkg::CFG_LOAD_OPCODE;
    lit_return_hit = instr.valid && is_lit_return(instr.word);
    cfg_write_hit = file_acc.wr && is_cfg_addr(file_acc.addr);
    cfg_read_hit = is_cfg_addr(file_acc.addr);
  end

  always_comb begin
    next_s = s;
    next_s.w_load = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.pop = 1'b0;
    next_s.flush = 1'b0;
    next_s.done = 1'b0;
    // Read data follows the stored value, one cycle behind the address
    next_s.rdata = cfg_read_hit ? s.cfg : decode_pkg::ZERO8;
    case (s.phase)
      decode_pkg::ST_FLUSH: begin
        // Second cycle discards the prefetched word
        next_s.phase = decode_pkg::ST_EXEC;
        next_s.done = 1'b1;
      end
      default: begin
        next_s.phase = decode_pkg::ST_EXEC;
        if (cfg_load_hit) begin
          next_s.cfg = w_reg;
          next_s.done = 1'b1;
        end else if (lit_return_hit) begin
          next_s.w_data = instr.word[decode_pkg::LIT_HI:decode_pkg::LIT_LO];
          next_s.w_load = 1'b1;
          next_s.pc_data = stack_top;
          next_s.pc_load = 1'b1;
          next_s.pop = 1'b1;
          next_s.flush = 1'b1;
          next_s.phase = decode_pkg::ST_FLUSH;
        end else if (cfg_write_hit) begin
          // Instruction load wins a same-cycle file write; both come from the core
          next_s.cfg = file_acc.wdata;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '{
        phase: decode_pkg::ST_EXEC,
        cfg: decode_pkg::CFG_RESET,
        w_data: decode_pkg::ZERO8,
        w_load: 1'b0,
        pc_data: decode_pkg::ZERO_PC,
        pc_load: 1'b0,
        pop: 1'b0,
        flush: 1'b0,
        done: 1'b0,
        rdata: decode_pkg::ZERO8
      };
    end else begin
      s <= next_s;
    end
  end

  assign cfg = s.cfg;
  assign file_rdata = s.rdata;
  assign w_data = s.w_data;
  assign w_load = s.w_load;
  assign pc_data = s.pc_data;
  assign pc_load = s.pc_load;
  assign stack_pop = s.pop;
  assign flush = s.flush;
  assign done = s.done;

  // Checks decode from the raw ports, not the hit signals, so a decode slip still shows
  sequence cfg_load_seen;
    instr.valid && instr.word == decode_pkg::CFG_LOAD_OPCODE && s.phase == decode_pkg::ST_EXEC;
  endsequence

  sequence lit_return_seen;
    instr.valid && instr.word[decode_pkg::TOP_HI:decode_pkg::TOP_LO] == decode_pkg::LIT_RETURN_TOP
      && s.phase == decode_pkg::ST_EXEC;
  endsequence

  sequence reload_step;
    pc_load && stack_pop && flush;
  endsequence

  sequence finish_step;
    done && !pc_load && !w_load && !flush;
  endsequence

  sequence two_cycle_finish;
    reload_step ##1 finish_step;
  endsequence

  a_reset_state: assert property (@(posedge core_clk)
    rst |=> cfg == decode_pkg::CFG_RESET && !done && !flush && !pc_load && !w_load)
    else $error("state not at reset values after reset");

  a_cfg_load_copy: assert property (@(posedge core_clk) disable iff (rst)
    cfg_load_seen |=> cfg == $past(w_reg) && done && !flush)
    else $error("config load did not copy working register");

  a_cfg_load_quiet: assert property (@(posedge core_clk) disable iff (rst)
    cfg_load_seen |=> !w_load && !pc_load && !stack_pop)
    else $error("config load touched working register or stack");

  a_cfg_load_single: assert property (@(posedge core_clk) disable iff (rst)
    cfg_load_seen |=> s.phase == decode_pkg::ST_EXEC)
    else $error("config load took more than one cycle");

  a_cfg_load_wins: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && instr.word == decode_pkg::CFG_LOAD_OPCODE && s.phase == decode_pkg::ST_EXEC
      && file_acc.wr && file_acc.addr == decode_pkg::CFG_ADDR
    |=> cfg == $past(w_reg))
    else $error("file write beat a same-cycle config load");

  a_file_write_cfg: assert property (@(posedge core_clk) disable iff (rst)
    file_acc.wr && file_acc.addr == decode_pkg::CFG_ADDR && !instr.valid && s.phase == decode_pkg::ST_EXEC
    |=> cfg == $past(file_acc.wdata) ##1 file_rdata == cfg || file_acc.addr != decode_pkg::CFG_ADDR)
    else $error("file write to config register lost");

  a_file_read_cfg: assert property (@(posedge core_clk) disable iff (rst)
    file_acc.addr == decode_pkg::CFG_ADDR |=> file_rdata == $past(cfg))
    else $error("file read of config register wrong");

  a_file_read_other: assert property (@(posedge core_clk) disable iff (rst)
    file_acc.addr != decode_pkg::CFG_ADDR |=> file_rdata == decode_pkg::ZERO8)
    else $error("file read of other address not zero");

  a_cfg_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    !instr.valid && !file_acc.wr |=> $stable(cfg))
    else $error("config register changed with no access");

  a_literal_load: assert property (@(posedge core_clk) disable iff (rst)
    lit_return_seen |=> w_load && w_data == $past(instr.word[decode_pkg::LIT_HI:decode_pkg::LIT_LO])
      && pc_data == $past(stack_top))
    else $error("literal return loaded wrong values");

  a_pop_with_reload: assert property (@(posedge core_clk) disable iff (rst)
    stack_pop == pc_load)
    else $error("stack pop and program counter reload apart");

  a_w_with_reload: assert property (@(posedge core_clk) disable iff (rst)
    w_load == pc_load)
    else $error("working register load without reload");

  a_literal_decode: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && s.phase == decode_pkg::ST_EXEC
      && instr.word[decode_pkg::TOP_HI:decode_pkg::TOP_LO] != decode_pkg::LIT_RETURN_TOP
    |=> !pc_load)
    else $error("literal return decoded from wrong pattern");

  a_literal_match: assert property (@(posedge core_clk) disable iff (rst)
    lit_return_seen |=> pc_load)
    else $error("literal return pattern not recognised");

  a_literal_two_cycle: assert property (@(posedge core_clk) disable iff (rst)
    lit_return_seen |=> two_cycle_finish)
    else $error("literal return did not take two cycles");

  a_flush_ignores: assert property (@(posedge core_clk) disable iff (rst)
    flush |=> $stable(cfg) && !w_load)
    else $error("prefetched word executed during flush");

  a_flush_single: assert property (@(posedge core_clk) disable iff (rst)
    flush |=> !flush && !pc_load)
    else $error("flush lasted more than one cycle");

  a_flush_phase: assert property (@(posedge core_clk) disable iff (rst)
    flush |-> s.phase == decode_pkg::ST_FLUSH)
    else $error("flush outside the refetch cycle");

  a_done_quiet: assert property (@(posedge core_clk) disable iff (rst)
    done |-> !w_load && !pc_load && !stack_pop)
    else $error("finish pulse overlapped a load");

  a_pop_single: assert property (@(posedge core_clk) disable iff (rst)
    stack_pop |=> !stack_pop)
    else $error("stack popped twice for one return");

  a_w_load_single: assert property (@(posedge core_clk) disable iff (rst)
    w_load |=> !w_load)
    else $error("working register loaded twice for one return");
endmodule
`default_nettype wire

// ===== decode_pkg.sv
// Purpose: Shared constants and carriers for the config-load and literal-return decoder
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter
// Notes: Field positions and opcodes are named here, never written in logic
`default_nettype none
package decode_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam logic [13:0] CFG_LOAD_OPCODE = 14'h0062;
  // Pattern 11 01xx: compare the top four bits only
  localparam logic [3:0] LIT_RETURN_TOP = 4'h_d;
  localparam int TOP_HI = 13;
  localparam int TOP_LO = 10;
  localparam int LIT_HI = 7;
  localparam int LIT_LO = 0;
  localparam logic [7:0] CFG_RESET = 8'h_ff;
  localparam logic [7:0] ZERO8 = 8'h_00;
  localparam logic [12:0] ZERO_PC = 13'h_0000;
  localparam logic [7:0] CFG_ADDR = 8'h_81;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_FLUSH = 3'b010,
    ST_IDLE = 3'b100
  } phase_t;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } instr_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } file_access_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] cfg;
    logic [7:0] w_data;
    logic w_load;
    logic [12:0] pc_data;
    logic pc_load;
    logic pop;
    logic flush;
    logic done;
    logic [7:0] rdata;
  } state_t;
endpackage
`default_nettype wire

// ===== core_model.sv
// Purpose: Stand-in for the core's W register and return stack
// Assumes: W is written on the decoder's load pulse
// Notes: Stack top is fixed because only pops are exercised
`default_nettype none
module core_model #(parameter logic [12:0] RET_ADDR = 13'h_0123) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] w_data,
  input wire logic w_load,
  output var logic [7:0] w_reg,
  output logic [12:0] stack_top
);
  timeunit 1ns;
  timeprecision 1ps;
  assign stack_top = RET_ADDR;
  always_ff @(posedge core_clk) begin
    if (rst) w_reg <= 8'h_00;
    else if (w_load) w_reg <= w_data;
  end
endmodule
`default_nettype wire

// ===== config_literal_decode_test.sv
// Purpose: Self-checking bench for the config and literal-return decoder
// Assumes: Outputs are looked at 1 ns after each edge
// Notes: A 300-cycle ceiling is ample for this short run
`default_nettype none
module config_literal_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  decode_pkg::instr_t instr = '0;
  decode_pkg::file_access_t file_acc = '0;
  logic [7:0] w_reg, cfg, file_rdata, w_data;
  logic [12:0] stack_top, pc_data;
  logic w_load, pc_load, stack_pop, flush, done;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  config_literal_decode DUT (.core_clk(core_clk), .rst(rst), .instr(instr), .w_reg(w_reg),
    .stack_top(stack_top), .file_acc(file_acc), .cfg(cfg), .file_rdata(file_rdata), .w_data(w_data),
    .w_load(w_load), .pc_data(pc_data), .pc_load(pc_load), .stack_pop(stack_pop), .flush(flush), .done(done));
  core_model core (.core_clk(core_clk), .rst(rst), .w_data(w_data), .w_load(w_load), .w_reg(w_reg),
    .stack_top(stack_top));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 300) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  task automatic run_literal_return(input logic [13:0] word);
    instr = '{1'b1, word};
    tick();
    instr = '0;
    chk({w_load, pc_load, stack_pop, flush, w_data}, {4'h_f, word[7:0]});
    chk(pc_data, 13'h_0123);
    tick();
    chk({done, w_load, pc_load, flush}, 4'h_8);
  endtask
  task automatic run_config_load(input logic [7:0] exp_w);
    instr = '{1'b1, decode_pkg::CFG_LOAD_OPCODE};
    tick();
    instr = '0;
    chk({done, w_load, pc_load, cfg}, {3'b100, exp_w});
  endtask
  task automatic run_ignored(input logic [13:0] word);
    instr = '{1'b1, word};
    tick();
    instr = '0;
    chk({done, w_load, pc_load, stack_pop, flush}, 5'h_00);
  endtask
  task automatic run_load_vs_write(input logic [7:0] exp_w, input logic [7:0] val);
    instr = '{1'b1, decode_pkg::CFG_LOAD_OPCODE};
    file_acc = '{1'b1, decode_pkg::CFG_ADDR, val};
    tick();
    instr = '0;
    file_acc.wr = 1'b0;
    chk(cfg, exp_w);
  endtask
  task automatic file_write(input logic [7:0] val);
    file_acc = '{1'b1, decode_pkg::CFG_ADDR, val};
    tick();
    file_acc.wr = 1'b0;
    chk(cfg, val);
    tick();
    chk(file_rdata, val);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) tick();
    rst = 1'b0;
    chk(cfg, decode_pkg::CFG_RESET);
    run_literal_return(14'h_37ab);
    run_literal_return(14'h_3655);
    run_config_load(8'h_55);
    file_write(8'h_a5);
    run_config_load(8'h_55);
    run_ignored(14'h_3355);
    run_load_vs_write(8'h_55, 8'h_3c);
    stop_test();
  end
endmodule
`default_nettype wire
